// File: common/ddsreg_pkg.sv
// Constants for the serial configuration, power-down and reset register group
package ddsreg_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [12:0] ADDR_PORT_CFG    = 13'h0000;
    localparam logic [12:0] ADDR_PART_IDENTIFIER_LO  = 13'h0002;
    localparam logic [12:0] ADDR_PART_IDENTIFIER_HI  = 13'h0003;
    localparam logic [12:0] ADDR_READBACK    = 13'h0004;
    localparam logic [12:0] ADDR_UPDATE      = 13'h0005;
    localparam logic [12:0] ADDR_POWER       = 13'h0010;
    localparam logic [12:0] ADDR_CORE_RST    = 13'h0012;
    localparam logic [12:0] ADDR_DIV_RST     = 13'h0013;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_FOUR_WIRE_BIT  = 0;
    localparam int CFG_LSB_FIRST_BIT  = 1;
    localparam int CFG_SOFT_RESET_BIT = 2;
    localparam int CFG_LONG_INSTR_BIT = 3;
    localparam int READ_BUF_BIT       = 0;
    localparam int UPDATE_BIT         = 0;
    localparam int PD_HSTL_BIT        = 7;
    localparam int PD_CMOS_BIT        = 6;
    localparam int PD_DOUBLER_BIT     = 5;
    localparam int PD_MULT_BIT        = 4;
    localparam int PD_FULL_BIT        = 1;
    localparam int PD_DIGITAL_BIT     = 0;
    localparam int CORE_RST_BIT       = 0;
    localparam int DIV_FUND_BIT       = 7;
    localparam int DIV_PRESCALE_BIT   = 3;
    localparam int DIV_INT_BIT        = 1;
    localparam int STRAP_MULT_PIN     = 3;
    localparam int INSTR_READ_BIT     = 15;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0]  PD_RESET       = 8'hC0;
    localparam logic [7:0]  PD_WRITE_MASK  = 8'hF3;
    localparam logic [7:0]  DIV_RESET      = 8'h00;
    localparam logic [7:0]  DIV_WRITE_MASK = 8'h8A;
    // Arbitrary identification value
    localparam logic [15:0] PART_IDENTIFIER        = 16'h5A3C;
    // Synchroniser idle: chip select high, all else low
    localparam logic [8:0]  PIN_IDLE       = 9'h080;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam logic [3:0]  INSTR_LAST_BIT = 4'hF;
    localparam logic [3:0]  BYTE_LAST_BIT  = 4'h7;
    localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_INSTR = 2'b01,
        PH_DATA  = 2'b10
    } phase_t;
endpackage

// File: rtl/serial_cfg_powerdown_reset_regs.sv
// Serial control port slave with configuration, power-down and reset registers
`timescale 1ns/1ps
module serial_cfg_powerdown_reset_regs
    import ddsreg_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_b_i,
    input  wire logic       sdio_i,
    input  wire logic       io_update_i,
    input  wire logic       power_down_pin_i,
    input  wire logic [3:0] startup_config_pins_i,
    input  wire logic       doubler_enable_i,
    output logic            sdio_o,
    output logic            sdio_oe_o,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    output logic            hstl_off_o,
    output logic            cmos_on_o,
    output logic            doubler_on_o,
    output logic            clock_multiplier_off_o,
    output logic            full_power_down_o,
    output logic            system_clock_stop_o,
    output logic            digital_core_sleep_o,
    output logic            synth_core_reset_o,
    output logic            fundamental_output_off_o,
    output logic            prescaler_reset_o,
    output logic            divider_reset_o
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [8:0]  pin_m;
    logic [8:0]  pin_s;
    logic [8:0]  pin_d;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_act;
    logic        upd_rise;
    logic        sdin;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_m <= PIN_IDLE;
            pin_s <= PIN_IDLE;
            pin_d <= PIN_IDLE;
        end else begin
            pin_m <= {sclk_i, cs_b_i, sdio_i, io_update_i, power_down_pin_i,
                      startup_config_pins_i};
            pin_s <= pin_m;
            pin_d <= pin_s;
        end
    end

    assign sclk_rise = pin_s[8] & ~pin_d[8];
    assign sclk_fall = ~pin_s[8] & pin_d[8];
    assign cs_act    = ~pin_s[7];
    assign sdin      = pin_s[6];
    assign upd_rise  = pin_s[5] & ~pin_d[5];

    // ****************************************
    // Register state
    // ****************************************
    logic        four_wire_select;
    logic        lsb_pend;
    logic        lsb_act;
    logic        soft_rst;
    logic        read_buf_sel;
    logic [7:0]  pd_reg;
    logic [7:0]  div_ctl;
    logic [7:0]  pd_default;
    logic [3:0]  strap;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic        wr_en;
    logic [12:0] wr_addr;
    logic [7:0]  wr_data;
    logic        sw_update;
    logic        update;
    logic        core_rst_req;
    logic [7:0]  rd_cfg;

    function automatic logic [7:0] read_reg(input logic [12:0] a);
        logic [7:0] d;
        logic [3:0] lo;
        d  = 8'h00;
        lo = {1'b1, soft_rst, (read_buf_sel ? lsb_pend : lsb_act), four_wire_select};
        case (a)
            ADDR_PORT_CFG:   d = {lo[0], lo[1], lo[2], lo[3], lo};
            ADDR_PART_IDENTIFIER_LO: d = PART_IDENTIFIER[7:0];
            ADDR_PART_IDENTIFIER_HI: d = PART_IDENTIFIER[15:8];
            ADDR_READBACK:   d[READ_BUF_BIT] = read_buf_sel;
            ADDR_POWER:      d = pd_reg;
            ADDR_DIV_RST:    d = div_ctl;
            default:         d = 8'h00;
        endcase
        return d;
    endfunction

    // Process form, so the readback follows the state that the function reads
    always_comb rd_cfg = read_reg(ADDR_PORT_CFG);
    assign sw_update    = wr_en && (wr_addr == ADDR_UPDATE) && wr_data[UPDATE_BIT];
    assign update       = upd_rise | sw_update;
    assign core_rst_req = wr_en && (wr_addr == ADDR_CORE_RST) && wr_data[CORE_RST_BIT];
    assign strap_done   = (strap_cnt == STRAP_SETTLE);

    // ****************************************
    // Serial protocol engine
    // ****************************************
    phase_t      phase;
    logic [3:0]  bit_cnt;
    logic [15:0] shift;
    logic [15:0] next_shift;
    logic [12:0] addr;
    logic [12:0] next_addr;
    logic        rd_mode;
    logic [7:0]  tx;
    logic [7:0]  rx_byte;

    // shift order from active bit order
    assign next_shift = lsb_act ? {sdin, shift[15:1]} : {shift[14:0], sdin};
    assign rx_byte    = lsb_act ? next_shift[15:8] : next_shift[7:0];
    // Streaming walks up in LSB-first order, down otherwise
    assign next_addr  = lsb_act ? 13'(addr + 13'h0001) : 13'(addr - 13'h0001);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase   <= PH_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 16'h0000;
            addr    <= 13'h0000;
            rd_mode <= 1'b0;
            tx      <= 8'h00;
            wr_en   <= 1'b0;
            wr_addr <= 13'h0000;
            wr_data <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (!cs_act) begin
                phase   <= PH_IDLE;
                bit_cnt <= 4'h0;
                rd_mode <= 1'b0;
            end else if (sclk_rise) begin
                shift   <= next_shift;
                bit_cnt <= 4'(bit_cnt + 4'h1);
                unique case (phase)
                    PH_IDLE, PH_INSTR: begin
                        phase <= PH_INSTR;
                        if (bit_cnt == INSTR_LAST_BIT) begin
                            phase   <= PH_DATA;
                            bit_cnt <= 4'h0;
                            rd_mode <= next_shift[INSTR_READ_BIT];
                            addr    <= next_shift[12:0];
                            tx      <= read_reg(next_shift[12:0]);
                        end
                    end
                    PH_DATA: begin
                        if (bit_cnt == BYTE_LAST_BIT) begin
                            bit_cnt <= 4'h0;
                            wr_en   <= ~rd_mode;
                            wr_addr <= addr;
                            wr_data <= rx_byte;
                            addr    <= next_addr;
                            tx      <= read_reg(next_addr);
                        end
                    end
                    default: phase <= PH_IDLE;
                endcase
            end
        end
    end

    // pin choice by wire mode; bits change on falling clock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sdio_o    <= 1'b0;
            sdo_o     <= 1'b0;
            sdio_oe_o <= 1'b0;
            sdo_oe_o  <= 1'b0;
        end else begin
            sdio_oe_o <= cs_act && (phase == PH_DATA) && rd_mode && !four_wire_select;
            sdo_oe_o  <= cs_act && (phase == PH_DATA) && rd_mode && four_wire_select;
            if (sclk_fall && phase == PH_DATA) begin
                sdio_o <= lsb_act ? tx[bit_cnt[2:0]] : tx[3'(3'h7 - bit_cnt[2:0])];
                sdo_o  <= lsb_act ? tx[bit_cnt[2:0]] : tx[3'(3'h7 - bit_cnt[2:0])];
            end
        end
    end

    // ****************************************
    // Start-up pin capture
    // ****************************************
    // Pins are caught only after hard reset release; soft reset never re-samples
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_cnt <= 2'h0;
            strap     <= 4'h0;
        end else if (!strap_done) begin
            strap_cnt <= 2'(strap_cnt + 2'h1);
            strap     <= pin_s[3:0];
        end
    end

    always_comb begin
        pd_default = PD_RESET;
        // pin three sets multiplier power-down default
        // Last forced load falls in the capture cycle, so it must see the live pin
        pd_default[PD_MULT_BIT] = strap_done ? strap[STRAP_MULT_PIN] : pin_s[STRAP_MULT_PIN];
    end

    // ****************************************
    // Port configuration register
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            four_wire_select <= 1'b0;
            lsb_pend         <= 1'b0;
            soft_rst         <= 1'b0;
            lsb_act          <= 1'b0;
        end else begin
            if (wr_en && wr_addr == ADDR_PORT_CFG) begin
                four_wire_select <= wr_data[CFG_FOUR_WIRE_BIT];
                lsb_pend         <= wr_data[CFG_LSB_FIRST_BIT];
                // soft reset stays until host clears it
                soft_rst         <= wr_data[CFG_SOFT_RESET_BIT];
            end
            // bit order moves at update only
            if (update) begin
                lsb_act <= lsb_pend;
            end
        end
    end

    // ****************************************
    // Power-down, readback and divider registers
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_reg       <= PD_RESET;
            read_buf_sel <= 1'b0;
            div_ctl      <= DIV_RESET;
        end else if (soft_rst || !strap_done) begin
            // held at defaults while soft reset set
            pd_reg       <= pd_default;
            read_buf_sel <= 1'b0;
            div_ctl      <= DIV_RESET;
        end else if (wr_en) begin
            case (wr_addr)
                ADDR_READBACK: read_buf_sel <= wr_data[READ_BUF_BIT];
                ADDR_POWER:    pd_reg       <= wr_data & PD_WRITE_MASK;
                ADDR_DIV_RST:  div_ctl      <= wr_data & DIV_WRITE_MASK;
                default:       read_buf_sel <= read_buf_sel;
            endcase
        end
    end

    // ****************************************
    // Control outputs
    // ****************************************
    // Prescaler and divider resets are levels; the divider domain applies them
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hstl_off_o               <= PD_RESET[PD_HSTL_BIT];
            cmos_on_o                <= PD_RESET[PD_CMOS_BIT];
            doubler_on_o             <= 1'b0;
            clock_multiplier_off_o   <= 1'b0;
            full_power_down_o        <= 1'b0;
            system_clock_stop_o      <= 1'b0;
            digital_core_sleep_o     <= 1'b0;
            synth_core_reset_o       <= 1'b0;
            fundamental_output_off_o <= 1'b0;
            prescaler_reset_o        <= 1'b0;
            divider_reset_o          <= 1'b0;
        end else begin
            hstl_off_o               <= pd_reg[PD_HSTL_BIT];
            cmos_on_o                <= pd_reg[PD_CMOS_BIT];
            doubler_on_o             <= pd_reg[PD_DOUBLER_BIT] & doubler_enable_i;
            clock_multiplier_off_o   <= pd_reg[PD_MULT_BIT];
            full_power_down_o        <= pd_reg[PD_FULL_BIT] | pin_s[4];
            system_clock_stop_o      <= pd_reg[PD_FULL_BIT] | pin_s[4];
            digital_core_sleep_o     <= pd_reg[PD_DIGITAL_BIT];
            // one-cycle core reset, bit never stored
            synth_core_reset_o       <= core_rst_req;
            fundamental_output_off_o <= div_ctl[DIV_FUND_BIT];
            prescaler_reset_o        <= div_ctl[DIV_PRESCALE_BIT];
            divider_reset_o          <= div_ctl[DIV_INT_BIT];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_cfg_mirror_bits: assert property (
        rd_cfg[7:4] == {rd_cfg[0], rd_cfg[1], rd_cfg[2], rd_cfg[3]})
        else $error("port configuration upper nibble is not mirrored");
    a_long_instr_flag: assert property (
        rd_cfg[CFG_LONG_INSTR_BIT] && rd_cfg[7 - CFG_LONG_INSTR_BIT])
        else $error("long instruction flag not reading one");
    a_soft_reset_defaults: assert property (
        soft_rst && strap_done |=> pd_reg == $past(pd_default) && div_ctl == DIV_RESET
                                   && !read_buf_sel)
        else $error("soft reset did not restore defaults");
    a_strap_kept: assert property (
        strap_done |=> $stable(strap) && strap_done)
        else $error("start-up pins sampled again after capture");
    a_order_hold: assert property (
        !update |=> $stable(lsb_act))
        else $error("bit order changed without update");
    a_order_load: assert property (
        update |=> lsb_act == $past(lsb_pend))
        else $error("pending bit order not applied on update");
    a_sw_update_equal: assert property (
        sw_update && (lsb_pend != lsb_act) |=> lsb_act != $past(lsb_act))
        else $error("software update had no effect");
    a_wire_mode_pins: assert property (
        !(sdio_oe_o && sdo_oe_o) && (!sdo_oe_o || $past(four_wire_select)))
        else $error("data output pin driven in wrong wire mode");
    a_readback_select: assert property (
        read_buf_sel |-> rd_cfg[CFG_LSB_FIRST_BIT] == lsb_pend)
        else $error("readback did not show pending value");
    a_core_reset_pulse: assert property (
        core_rst_req |=> synth_core_reset_o && read_reg(ADDR_CORE_RST) == 8'h00)
        else $error("core reset did not pulse or did not clear");
    a_hstl_write_path: assert property (
        wr_en && wr_addr == ADDR_POWER && !soft_rst && strap_done
            |=> ##1 hstl_off_o == $past(wr_data[PD_HSTL_BIT], 2))
        else $error("driver power-down bit did not reach output");
    a_doubler_gate: assert property (
        doubler_on_o |-> $past(pd_reg[PD_DOUBLER_BIT]) && $past(doubler_enable_i))
        else $error("doubler on without both enables");
    a_full_power_down_bit_clock: assert property (
        full_power_down_o == system_clock_stop_o)
        else $error("full power-down did not stop system clock");

endmodule

// File: tb/serial_host_model.sv
// Behavioural host controller that drives the serial control port
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic sys_clk_i,
    input  wire logic sdio_i,
    input  wire logic sdio_oe_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      sdio_o,
    output logic      sdio_oe_o
);
    logic oe_ok;

    initial begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        sdio_o = 1'b0;
        sdio_oe_o = 1'b0;
        oe_ok = 1'b1;
    end

    // ****************************************
    // Bit and frame tasks
    // ****************************************
    // Six cycles per level keeps the pin well above the three-cycle minimum
    task automatic clk_bit(input logic d, input logic drv, input logic fw, output logic q);
        @(posedge sys_clk_i) #1;
        sclk_o = 1'b0;
        if (drv) begin
            sdio_o = d;
        end
        sdio_oe_o = drv;
        repeat (6) @(posedge sys_clk_i);
        #1;
        q = fw ? sdo_i : sdio_i;
        if (!drv) begin
            oe_ok = oe_ok & (fw ? (sdo_oe_i & ~sdio_oe_i) : (sdio_oe_i & ~sdo_oe_i));
        end
        sclk_o = 1'b1;
        repeat (5) @(posedge sys_clk_i);
    endtask

    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                        input int nbytes, input logic lsb, input logic fw,
                        output logic [15:0] rdata);
        logic [15:0] instr;
        logic        q;
        instr = {rd, 2'b00, addr};
        rdata = '0;
        @(posedge sys_clk_i) #1;
        cs_b_o = 1'b0;
        for (int i = 0; i < 16; i++) begin
            clk_bit(instr[lsb ? i : 15 - i], 1'b1, fw, q);
        end
        for (int k = 0; k < nbytes; k++) begin
            rdata = rdata << 8;
            for (int j = 0; j < 8; j++) begin
                clk_bit(wd[lsb ? j : 7 - j], !rd, fw, q);
                rdata[lsb ? j : 7 - j] = q;
            end
        end
        @(posedge sys_clk_i) #1;
        cs_b_o = 1'b1;
        sdio_oe_o = 1'b0;
        repeat (10) @(posedge sys_clk_i);
    endtask
endmodule

// File: tb/serial_cfg_powerdown_reset_regs_tb_top.sv
// Self-checking testbench for the configuration, power-down and reset registers
`timescale 1ns/1ps
module serial_cfg_powerdown_reset_regs_tb_top;
    import ddsreg_pkg::*;
    logic        sys_clk, rst_b, io_update, pd_pin, dbl_en, sclk, cs_b, host_d, host_oe;
    logic        dut_sdio, sdio_oe, sdo, sdo_oe, core_rst, lsb, fw;
    logic [3:0]  straps;
    logic [9:0]  outs;
    logic [15:0] rd_val;
    wire         sdio_line;
    int          err_total = 0;
    int          cmp_count = 0;
    int          pulse_cnt = 0;
    int          cycles = 0;

    // Undriven line shows the inverse of the host's last driven bit
    assign sdio_line = sdio_oe ? dut_sdio : (host_oe ? host_d : ~host_d);

    serial_cfg_powerdown_reset_regs dut (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .sclk_i(sclk), .cs_b_i(cs_b),
        .sdio_i(sdio_line), .io_update_i(io_update), .power_down_pin_i(pd_pin),
        .startup_config_pins_i(straps), .doubler_enable_i(dbl_en), .sdio_o(dut_sdio),
        .sdio_oe_o(sdio_oe), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .hstl_off_o(outs[9]),
        .cmos_on_o(outs[8]), .doubler_on_o(outs[7]), .clock_multiplier_off_o(outs[6]),
        .full_power_down_o(outs[5]), .system_clock_stop_o(outs[4]),
        .digital_core_sleep_o(outs[3]), .synth_core_reset_o(core_rst),
        .fundamental_output_off_o(outs[2]), .prescaler_reset_o(outs[1]),
        .divider_reset_o(outs[0]));

    serial_host_model host (
        .sys_clk_i(sys_clk), .sdio_i(sdio_line), .sdio_oe_i(sdio_oe), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_b_o(cs_b), .sdio_o(host_d),
        .sdio_oe_o(host_oe));

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (core_rst === 1'b1) begin
            pulse_cnt++;
        end
        if (cycles == 40000) begin
            err_total++;
            $display("mismatch at %0t: run did not finish", $time);
            summarize();
        end
    end

    // ****************************************
    // Access and comparison tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, 1, lsb, fw, rd_val);
    endtask

    task automatic rd(input logic [12:0] a, input int n);
        host.xfer(1'b1, a, 8'h00, n, lsb, fw, rd_val);
    endtask

    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {sys_clk, rst_b, io_update, pd_pin, dbl_en, lsb, fw} = '0;
        straps = 4'h8;
        repeat (4) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1 straps = 4'h0;
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h0018);
        check({15'h0, host.oe_ok}, 16'h0001);
        rd(ADDR_POWER, 1);
        check(rd_val, 16'h00D0);
        check({6'h0, outs}, 16'h0340);
        rd(ADDR_PART_IDENTIFIER_HI, 2);
        check(rd_val, PART_IDENTIFIER);
        wr(13'h0001, 8'hFF);
        rd(13'h0001, 1);
        check(rd_val, 16'h0000);
        #1 dbl_en = 1'b1;
        wr(ADDR_POWER, 8'hFF);
        rd(ADDR_POWER, 1);
        check(rd_val, 16'h00F3);
        check({6'h0, outs}, 16'h03F8);
        @(posedge sys_clk) #1 dbl_en = 1'b0;
        repeat (3) @(posedge sys_clk);
        check({6'h0, outs}, 16'h0378);
        wr(ADDR_POWER, 8'h00);
        @(posedge sys_clk) #1 pd_pin = 1'b1;
        repeat (6) @(posedge sys_clk);
        check({6'h0, outs}, 16'h0030);
        #1 pd_pin = 1'b0;
        wr(ADDR_DIV_RST, 8'hFF);
        rd(ADDR_DIV_RST, 1);
        check(rd_val, 16'h008A);
        check({6'h0, outs}, 16'h0007);
        check(pulse_cnt[15:0], 16'h0000);
        wr(ADDR_CORE_RST, 8'h01);
        check(pulse_cnt[15:0], 16'h0001);
        // Straps now low, so the power default must still come from the hard reset
        wr(ADDR_PORT_CFG, 8'h04);
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h003C);
        rd(ADDR_POWER, 1);
        check(rd_val, 16'h00D0);
        rd(ADDR_DIV_RST, 1);
        check(rd_val, 16'h0000);
        wr(ADDR_PORT_CFG, 8'h00);
        wr(ADDR_POWER, 8'h10);
        rd(ADDR_POWER, 1);
        check(rd_val, 16'h0010);
        wr(ADDR_PORT_CFG, 8'h02);
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h0018);
        wr(ADDR_READBACK, 8'h01);
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h005A);
        wr(ADDR_UPDATE, 8'h01);
        lsb = 1'b1;
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h005A);
        wr(ADDR_READBACK, 8'h00);
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h005A);
        wr(ADDR_PORT_CFG, 8'h00);
        @(posedge sys_clk) #1 io_update = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 io_update = 1'b0;
        repeat (6) @(posedge sys_clk);
        lsb = 1'b0;
        rd(ADDR_PORT_CFG, 1);
        check(rd_val, 16'h0018);
        wr(ADDR_PORT_CFG, 8'h01);
        fw = 1'b1;
        host.oe_ok = 1'b1;
        rd(ADDR_POWER, 1);
        check(rd_val, 16'h0010);
        check({15'h0, host.oe_ok}, 16'h0001);
        summarize();
    end
endmodule
